// ### res_pkg.sv
// Constants shared by the retirement event selector and its slot matcher.
// Assumes an APB bus with 32-bit data and a retirement stage of four slots per cycle.
package res_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SLOTS = 4;
  localparam int CNT_W = 3;
  localparam int NUM_CNT = 6;
  localparam int NUM_SEL = 6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CODE_HI = 31;
  localparam int CODE_LO = 25;
  localparam int MASK_HI = 24;
  localparam int MASK_LO = 9;
  localparam int USEL_HI = 15;
  localparam int USEL_LO = 13;
  localparam int CFG_EN_BIT = 12;

  // ----------------------------------------------------------------
  // Event codes and unit selects
  // ----------------------------------------------------------------
  localparam logic [6:0] EV_UOPS_RETIRED = 7'h01;
  localparam logic [6:0] EV_INSTR_RETIRED = 7'h02;
  localparam logic [6:0] EV_UOP_TYPE = 7'h02;
  localparam logic [6:0] EV_BRANCH_RETIRED = 7'h06;
  localparam logic [2:0] USEL_RETIRE_LO = 3'h4;
  localparam logic [2:0] USEL_RETIRE_HI = 3'h5;
  localparam logic [2:0] USEL_RENAME = 3'h2;

  // ----------------------------------------------------------------
  // Mask bit positions
  // ----------------------------------------------------------------
  localparam int good_path_untagged_sel = 0;
  localparam int good_path_tagged_sel = 1;
  localparam int wrong_path_untagged_sel = 2;
  localparam int wrong_path_tagged_sel = 3;
  localparam int good_path_sel = 0;
  localparam int wrong_path_sel = 1;
  localparam int mark_load_ops = 1;
  localparam int mark_store_ops = 2;
  localparam int not_taken_predicted_sel = 0;
  localparam int not_taken_mispredicted_sel = 1;
  localparam int taken_predicted_sel = 2;
  localparam int taken_mispredicted_sel = 3;

  // ----------------------------------------------------------------
  // Register word indices (byte address = index * 4) and reset value
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_RETIRE_SEL_A = 4'h0;
  localparam logic [3:0] IDX_RETIRE_SEL_B = 4'h1;
  localparam logic [3:0] IDX_RETIRE_SEL_C = 4'h2;
  localparam logic [3:0] IDX_RETIRE_SEL_D = 4'h3;
  localparam logic [3:0] IDX_RENAME_SEL_A = 4'h4;
  localparam logic [3:0] IDX_RENAME_SEL_B = 4'h5;
  localparam logic [3:0] IDX_CFG_BASE = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'hC;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

endpackage

// ### res_slot_match.sv
// Slot matcher: counts retiring items that match one event selection.
// Assumes all retirement inputs come from logic on the same clock.
module res_slot_match
  import res_pkg::*;
(
  input wire logic [6:0] event_code,
  input wire logic [15:0] event_mask,
  input wire logic [2:0] unit_sel,
  input wire logic count_en,
  input wire logic [SLOTS-1:0] instr_valid,
  input wire logic [SLOTS-1:0] instr_wrong_path,
  input wire logic [SLOTS-1:0] instr_tagged,
  input wire logic [SLOTS-1:0] uop_valid,
  input wire logic [SLOTS-1:0] uop_wrong_path,
  input wire logic [SLOTS-1:0] br_valid,
  input wire logic [SLOTS-1:0] br_taken,
  input wire logic [SLOTS-1:0] br_mispred,
  output logic [CNT_W-1:0] match_count
);

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  wire logic is_retire_lo = count_en && (unit_sel == USEL_RETIRE_LO); // RULE_08
  wire logic is_retire_hi = count_en && (unit_sel == USEL_RETIRE_HI);
  wire logic do_instr = is_retire_lo && (event_code == EV_INSTR_RETIRED);   // RULE_01
  wire logic do_uops = is_retire_lo && (event_code == EV_UOPS_RETIRED);     // RULE_03
  wire logic do_branch = is_retire_hi && (event_code == EV_BRANCH_RETIRED); // RULE_09
  logic [SLOTS-1:0] hit;

  // ----------------------------------------------------------------
  // Per-slot match
  // ----------------------------------------------------------------
  for (genvar s = 0; s < SLOTS; s++)
  begin : g_slot
    // Long flows interrupted before retirement may report the same instruction again
    wire logic ins_m = (event_mask[good_path_untagged_sel] && !instr_wrong_path[s]
                        && !instr_tagged[s])
                    || (event_mask[good_path_tagged_sel] && !instr_wrong_path[s]
                        && instr_tagged[s])
                    || (event_mask[wrong_path_untagged_sel] && instr_wrong_path[s]
                        && !instr_tagged[s])
                    || (event_mask[wrong_path_tagged_sel] && instr_wrong_path[s]
                        && instr_tagged[s]); // RULE_01 RULE_02
    wire logic uop_m = (event_mask[good_path_sel] && !uop_wrong_path[s])
                    || (event_mask[wrong_path_sel] && uop_wrong_path[s]); // RULE_04
    wire logic br_m = (event_mask[not_taken_predicted_sel] && !br_taken[s] && !br_mispred[s])
                   || (event_mask[not_taken_mispredicted_sel] && !br_taken[s] && br_mispred[s])
                   || (event_mask[taken_predicted_sel] && br_taken[s] && !br_mispred[s]) // RULE_10
                   || (event_mask[taken_mispredicted_sel] && br_taken[s] && br_mispred[s]);
    assign hit[s] = (do_instr && instr_valid[s] && ins_m)
                 || (do_uops && uop_valid[s] && uop_m)
                 || (do_branch && br_valid[s] && br_m);
  end

  // Sum of matching slots, zero when none match
  always_comb
  begin
    match_count = '0;
    for (int s = 0; s < SLOTS; s++)
    begin
      match_count = match_count + CNT_W'(hit[s]); // RULE_12
    end
  end

endmodule // res_slot_match

// ### res_event_select.sv
// Retirement event selector: selection registers on APB, per-counter increments.
// Assumes retirement and rename inputs are synchronous to clk; counters live outside.
// Functional notes
// RULE_01: Event 02H counts instructions, four mask bits split good/wrong path and tagging.
// RULE_02: An interrupted long micro-op flow may count its instruction more than once.
// RULE_03: Event 01H with unit select 04H counts micro-ops retiring each cycle.
// RULE_04: Micro-op mask bit 0 selects good path, bit 1 wrong path.
// RULE_05: First register of a pair feeds counters 12,13,16; second feeds 14,15,17.
// RULE_06: Event 02H with select 02H marks micro-ops on the rename registers.
// RULE_07: Marking mask bit 1 tags loads, bit 2 tags stores.
// RULE_08: Load and store marking never makes any counter increment.
// RULE_09: Event 06H with select 05H counts retiring branches of enabled classes.
// RULE_10: Branch mask bits 0-3: not-taken predicted/mispredicted, taken predicted/mispredicted.
// RULE_11: Code from bits 31:25, mask from 24:9, unit select from 15:13.
// RULE_12: Each cycle add the count of matching items, nothing when none match.
//
// The placing of the registers and the APB interface to the registers were decided locally.
module res_event_select
  import res_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SLOTS-1:0] ret_instr_valid,
  input wire logic [SLOTS-1:0] ret_instr_wrong_path,
  input wire logic [SLOTS-1:0] ret_instr_tagged,
  input wire logic [SLOTS-1:0] ret_uop_valid,
  input wire logic [SLOTS-1:0] ret_uop_wrong_path,
  input wire logic [SLOTS-1:0] ret_br_valid,
  input wire logic [SLOTS-1:0] ret_br_taken,
  input wire logic [SLOTS-1:0] ret_br_mispred,
  input wire logic [SLOTS-1:0] ren_uop_valid,
  input wire logic [SLOTS-1:0] ren_uop_is_load,
  input wire logic [SLOTS-1:0] ren_uop_is_store,
  output logic [NUM_CNT-1:0][CNT_W-1:0] count_incr,
  output logic [SLOTS-1:0] mark_tag
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] event_selection_reg_ff [NUM_SEL];
  logic [31:0] counter_config_reg_ff [NUM_CNT];
  logic [NUM_CNT-1:0][CNT_W-1:0] incr_ff;
  logic [NUM_CNT-1:0][CNT_W-1:0] nxt_incr;
  logic [SLOTS-1:0] mark_ff;
  logic [31:0] rdata_ff;
  logic armed_ff;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic [3:0] word_idx = paddr[5:2];
  wire logic in_range = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
  wire logic hit_sel = in_range && (word_idx < IDX_CFG_BASE);
  wire logic hit_cfg = in_range && (word_idx >= IDX_CFG_BASE) && (word_idx < IDX_STATUS);
  wire logic hit_status = in_range && (word_idx == IDX_STATUS);
  wire logic mapped = hit_sel || hit_cfg || hit_status;
  wire logic [3:0] cfg_idx = word_idx - IDX_CFG_BASE;
  wire logic apb_done = psel && penable && pready;
  wire logic wr_sel = apb_done && pwrite && hit_sel;
  wire logic wr_cfg = apb_done && pwrite && hit_cfg;
  wire logic [31:0] status_word = {14'h0000, incr_ff};
  wire logic [31:0] rd_word = hit_sel ? event_selection_reg_ff[word_idx[2:0]]
                            : hit_cfg ? counter_config_reg_ff[cfg_idx[2:0]]
                            : hit_status ? status_word : REG_RESET;

  // Data is captured on the same enabled edge that sets armed_ff and lets pready rise
  assign pready = ce && penable && armed_ff;
  assign pslverr = pready && !mapped;
  assign prdata = rdata_ff;
  assign count_incr = incr_ff;
  assign mark_tag = mark_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      armed_ff <= 1'b0;
      rdata_ff <= REG_RESET;
    end
    else if (ce)
    begin
      armed_ff <= psel && !apb_done;
      rdata_ff <= psel ? rd_word : rdata_ff;
    end
  end

  // ----------------------------------------------------------------
  // Selection and configuration registers
  // ----------------------------------------------------------------
  for (genvar r = 0; r < NUM_SEL; r++)
  begin : g_selreg
    always_ff @(posedge clk)
    begin
      if (srst)
        event_selection_reg_ff[r] <= REG_RESET;
      else if (wr_sel && (word_idx == 4'(r)))
        event_selection_reg_ff[r] <= pwdata;
    end
  end

  for (genvar c = 0; c < NUM_CNT; c++)
  begin : g_cfgreg
    always_ff @(posedge clk)
    begin
      if (srst)
        counter_config_reg_ff[c] <= REG_RESET;
      else if (wr_cfg && (cfg_idx == 4'(c)))
        counter_config_reg_ff[c] <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Per-counter source selection and matching
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CNT; c++)
  begin : g_cnt
    // Counters 12,13,16 sit in group a; 14,15,17 in group b
    localparam bit GRP_B = (c == 2) || (c == 3) || (c == 5);
    wire logic [31:0] cfg = counter_config_reg_ff[c];
    wire logic [2:0] usel = cfg[USEL_HI:USEL_LO]; // RULE_11
    wire logic [31:0] src = (usel == USEL_RETIRE_LO) ? event_selection_reg_ff[GRP_B ? 1 : 0]
                          : (usel == USEL_RETIRE_HI) ? event_selection_reg_ff[GRP_B ? 3 : 2]
                          : (usel == USEL_RENAME) ? event_selection_reg_ff[GRP_B ? 5 : 4]
                          : REG_RESET; // RULE_05
    res_slot_match u_match (
      .event_code(src[CODE_HI:CODE_LO]), // RULE_11
      .event_mask(src[MASK_HI:MASK_LO]),
      .unit_sel(usel),
      .count_en(cfg[CFG_EN_BIT]),
      .instr_valid(ret_instr_valid),
      .instr_wrong_path(ret_instr_wrong_path),
      .instr_tagged(ret_instr_tagged),
      .uop_valid(ret_uop_valid),
      .uop_wrong_path(ret_uop_wrong_path),
      .br_valid(ret_br_valid),
      .br_taken(ret_br_taken),
      .br_mispred(ret_br_mispred),
      .match_count(nxt_incr[c])
    );
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      incr_ff <= '0;
    else if (ce)
      incr_ff <= nxt_incr; // RULE_12
  end

  // ----------------------------------------------------------------
  // Load and store marking on the rename registers
  // ----------------------------------------------------------------
  wire logic [31:0] ren_a = event_selection_reg_ff[IDX_RENAME_SEL_A[2:0]];
  wire logic [31:0] ren_b = event_selection_reg_ff[IDX_RENAME_SEL_B[2:0]];
  wire logic ren_a_on = ren_a[CODE_HI:CODE_LO] == EV_UOP_TYPE;
  wire logic ren_b_on = ren_b[CODE_HI:CODE_LO] == EV_UOP_TYPE;
  wire logic tag_loads = (ren_a_on && ren_a[MASK_LO + mark_load_ops])
                      || (ren_b_on && ren_b[MASK_LO + mark_load_ops]);
  wire logic tag_stores = (ren_a_on && ren_a[MASK_LO + mark_store_ops])
                       || (ren_b_on && ren_b[MASK_LO + mark_store_ops]);
  wire logic [SLOTS-1:0] nxt_mark = ren_uop_valid
                                  & (({SLOTS{tag_loads}} & ren_uop_is_load)
                                  | ({SLOTS{tag_stores}} & ren_uop_is_store)); // RULE_06 RULE_07

  always_ff @(posedge clk)
  begin
    if (srst)
      mark_ff <= '0;
    else if (ce)
      mark_ff <= nxt_mark;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire logic [31:0] cfg0 = counter_config_reg_ff[0];
  wire logic [31:0] sel_a = event_selection_reg_ff[0];
  wire logic [31:0] sel_b = event_selection_reg_ff[1];
  wire logic [31:0] sel_c = event_selection_reg_ff[2];
  wire logic cnt0_on = cfg0[CFG_EN_BIT];
  wire logic [2:0] cnt0_usel = cfg0[USEL_HI:USEL_LO];
  wire logic [31:0] cfg2 = counter_config_reg_ff[2];

  a_instr_good_untag: assert property (@(posedge clk) disable iff (srst) // RULE_01
    (ce && cnt0_on && cnt0_usel == USEL_RETIRE_LO && sel_a[CODE_HI:CODE_LO] == 7'h02
     && sel_a[MASK_HI:MASK_LO] == 16'h0001)
    |=> incr_ff[0] == CNT_W'($countones($past(ret_instr_valid) & ~$past(ret_instr_wrong_path)
        & ~$past(ret_instr_tagged))))
    else $error("instruction count wrong");

  a_uop_wrong_path: assert property (@(posedge clk) disable iff (srst) // RULE_04
    (ce && cnt0_on && cnt0_usel == USEL_RETIRE_LO && sel_a[CODE_HI:CODE_LO] == 7'h01
     && sel_a[MASK_HI:MASK_LO] == 16'h0002)
    |=> incr_ff[0] == CNT_W'($countones($past(ret_uop_valid) & $past(ret_uop_wrong_path))))
    else $error("wrong path micro-op count wrong");

  a_uop_all_paths: assert property (@(posedge clk) disable iff (srst) // RULE_03
    (ce && cnt0_on && cnt0_usel == USEL_RETIRE_LO && sel_a[CODE_HI:CODE_LO] == 7'h01
     && sel_a[MASK_HI:MASK_LO] == 16'h0003)
    |=> incr_ff[0] == CNT_W'($countones($past(ret_uop_valid))))
    else $error("micro-op count wrong");

  a_branch_taken_mis: assert property (@(posedge clk) disable iff (srst) // RULE_09
    (ce && cnt0_on && cnt0_usel == USEL_RETIRE_HI && sel_c[CODE_HI:CODE_LO] == 7'h06
     && sel_c[MASK_HI:MASK_LO] == 16'h0008)
    |=> incr_ff[0] == CNT_W'($countones($past(ret_br_valid) & $past(ret_br_taken)
        & $past(ret_br_mispred))))
    else $error("taken mispredicted branch count wrong");

  a_branch_nt_pred: assert property (@(posedge clk) disable iff (srst) // RULE_10
    (ce && cnt0_on && cnt0_usel == USEL_RETIRE_HI && sel_c[CODE_HI:CODE_LO] == 7'h06
     && sel_c[MASK_HI:MASK_LO] == 16'h0001)
    |=> incr_ff[0] == CNT_W'($countones($past(ret_br_valid) & ~$past(ret_br_taken)
        & ~$past(ret_br_mispred))))
    else $error("not-taken predicted branch count wrong");

  a_mark_no_incr: assert property (@(posedge clk) disable iff (srst) // RULE_08
    (ce && counter_config_reg_ff[0][USEL_HI:USEL_LO] == USEL_RENAME) |=> incr_ff[0] == '0)
    else $error("marking select incremented a counter");

  a_mark_loads: assert property (@(posedge clk) disable iff (srst) // RULE_07
    (ce && ren_a[CODE_HI:CODE_LO] == 7'h02 && ren_a[MASK_LO + 1] && !ren_b_on)
    |=> ((mark_ff & $past(ren_uop_valid) & $past(ren_uop_is_load))
         == ($past(ren_uop_valid) & $past(ren_uop_is_load))))
    else $error("load micro-op not marked");

  a_group_b_source: assert property (@(posedge clk) disable iff (srst) // RULE_05
    (ce && cfg2[CFG_EN_BIT] && cfg2[USEL_HI:USEL_LO] == USEL_RETIRE_LO
     && sel_b[CODE_HI:CODE_LO] == 7'h00) |=> incr_ff[2] == '0)
    else $error("counter 14 not fed by second register");

  a_zero_mask: assert property (@(posedge clk) disable iff (srst) // RULE_12
    (ce && sel_a[MASK_HI:MASK_LO] == 16'h0000 && cnt0_usel != USEL_RETIRE_HI)
    |=> incr_ff[0] == '0)
    else $error("count without enabled mask bit");

  a_unmapped_err: assert property (@(posedge clk) disable iff (srst) // RULE_11
    (pready && (paddr == 12'h034 || paddr == 12'h040)) |-> pslverr)
    else $error("unmapped access not flagged");

  // ----------------------------------------------------------------
  // Per-bit mask checks and the disabled counter check
  // ----------------------------------------------------------------
  wire logic cnt0_lo = ce && cnt0_on && cnt0_usel == USEL_RETIRE_LO;
  wire logic cnt0_hi = ce && cnt0_on && cnt0_usel == USEL_RETIRE_HI;
  wire logic [6:0] code_a = sel_a[CODE_HI:CODE_LO];
  wire logic [6:0] code_c = sel_c[CODE_HI:CODE_LO];
  wire logic [15:0] mask_a = sel_a[MASK_HI:MASK_LO];
  wire logic [15:0] mask_c = sel_c[MASK_HI:MASK_LO];

  a_instr_good_tag: assert property (@(posedge clk) disable iff (srst) // RULE_01
    (cnt0_lo && code_a == 7'h02 && mask_a == 16'h0002) |=> incr_ff[0]
      == CNT_W'($countones($past(ret_instr_valid & ~ret_instr_wrong_path & ret_instr_tagged))))
    else $error("good path tagged instruction count wrong");

  a_instr_bad_untag: assert property (@(posedge clk) disable iff (srst) // RULE_01
    (cnt0_lo && code_a == 7'h02 && mask_a == 16'h0004) |=> incr_ff[0]
      == CNT_W'($countones($past(ret_instr_valid & ret_instr_wrong_path & ~ret_instr_tagged))))
    else $error("wrong path untagged instruction count wrong");

  a_instr_bad_tag: assert property (@(posedge clk) disable iff (srst) // RULE_01
    (cnt0_lo && code_a == 7'h02 && mask_a == 16'h0008) |=> incr_ff[0]
      == CNT_W'($countones($past(ret_instr_valid & ret_instr_wrong_path & ret_instr_tagged))))
    else $error("wrong path tagged instruction count wrong");

  a_uop_good_path: assert property (@(posedge clk) disable iff (srst) // RULE_04
    (cnt0_lo && code_a == 7'h01 && mask_a == 16'h0001) |=> incr_ff[0]
      == CNT_W'($countones($past(ret_uop_valid & ~ret_uop_wrong_path))))
    else $error("good path micro-op count wrong");

  a_branch_nt_mis: assert property (@(posedge clk) disable iff (srst) // RULE_10
    (cnt0_hi && code_c == 7'h06 && mask_c == 16'h0002) |=> incr_ff[0]
      == CNT_W'($countones($past(ret_br_valid & ~ret_br_taken & ret_br_mispred))))
    else $error("not-taken mispredicted branch count wrong");

  a_branch_t_pred: assert property (@(posedge clk) disable iff (srst) // RULE_10
    (cnt0_hi && code_c == 7'h06 && mask_c == 16'h0004) |=> incr_ff[0]
      == CNT_W'($countones($past(ret_br_valid & ret_br_taken & ~ret_br_mispred))))
    else $error("taken predicted branch count wrong");

  a_mark_stores: assert property (@(posedge clk) disable iff (srst) // RULE_07
    (ce && ren_a[CODE_HI:CODE_LO] == 7'h02 && ren_a[MASK_HI:MASK_LO] == 16'h0004 && !ren_b_on)
    |=> mark_ff == $past(ren_uop_valid & ren_uop_is_store))
    else $error("store micro-op marking wrong");

  a_cnt_disabled: assert property (@(posedge clk) disable iff (srst) // RULE_12
    (ce && !cnt0_on) |=> incr_ff[0] == '0)
    else $error("disabled counter incremented");

endmodule // res_event_select

// ### res_pipe_model.sv
// Behavioural model of the retirement and rename stages that feed the selector.
// Assumes the bench asks for one pulse of slot activity at a time, on clk.
module res_pipe_model
  import res_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic fire,
  input wire logic [43:0] pat,
  output logic [SLOTS-1:0] instr_valid,
  output logic [SLOTS-1:0] instr_wrong_path,
  output logic [SLOTS-1:0] instr_tagged,
  output logic [SLOTS-1:0] uop_valid,
  output logic [SLOTS-1:0] uop_wrong_path,
  output logic [SLOTS-1:0] br_valid,
  output logic [SLOTS-1:0] br_taken,
  output logic [SLOTS-1:0] br_mispred,
  output logic [SLOTS-1:0] ren_valid,
  output logic [SLOTS-1:0] ren_load,
  output logic [SLOTS-1:0] ren_store
);
  timeunit 1ns;
  timeprecision 1ps;
  // Valid nibbles cleared, qualifier nibbles kept
  localparam logic [43:0] QUAL_ONLY = 44'hFF0_FF0F_0FF0;
  logic [43:0] drv_ff;
  logic [43:0] nxt_drv;

  // ----------------------------------------------------------------
  // Slot drive
  // ----------------------------------------------------------------
  // Idle cycles flip stale qualifiers so nothing leans on old values
  assign nxt_drv = fire ? pat : (~drv_ff & QUAL_ONLY);

  always_ff @(posedge clk)
  begin
    if (srst)
      drv_ff <= '0;
    else
      drv_ff <= nxt_drv;
  end

  assign {ren_store, ren_load, ren_valid, br_mispred, br_taken, br_valid,
          uop_wrong_path, uop_valid, instr_tagged, instr_wrong_path, instr_valid} = drv_ff;
endmodule // res_pipe_model

// ### res_event_select_test.sv
// Self-checking bench for the retirement event selector.
// Assumes a 50 MHz clk, APB register access and the slot model on the far side.
module res_event_select_test
  import res_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ce = 1'b1;
  logic fire = 1'b0;
  logic [43:0] pat = '0;
  logic [SLOTS-1:0] iv, iw, it, uv, uw, bv, bt, bm, rv, rl, rs;
  logic [NUM_CNT-1:0][CNT_W-1:0] count_incr;
  logic [SLOTS-1:0] mark_tag;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  res_pipe_model u_pipe (.clk(clk), .srst(srst), .fire(fire), .pat(pat),
    .instr_valid(iv), .instr_wrong_path(iw), .instr_tagged(it), .uop_valid(uv),
    .uop_wrong_path(uw), .br_valid(bv), .br_taken(bt), .br_mispred(bm),
    .ren_valid(rv), .ren_load(rl), .ren_store(rs));

  res_event_select u_dut (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ret_instr_valid(iv),
    .ret_instr_wrong_path(iw), .ret_instr_tagged(it), .ret_uop_valid(uv),
    .ret_uop_wrong_path(uw), .ret_br_valid(bv), .ret_br_taken(bt),
    .ret_br_mispred(bm), .ren_uop_valid(rv), .ren_uop_is_load(rl),
    .ren_uop_is_store(rs), .count_incr(count_incr), .mark_tag(mark_tag));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      results();
    end
    // Taken at the edge that samples pready high, released right after it
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] sel(input logic [6:0] code, input logic [15:0] m);
    return {code, m, 9'h000};
  endfunction

  task automatic cfg_all(input logic [2:0] usel);
    for (int i = 0; i < NUM_CNT; i++)
      apb(1'b1, 12'h018 + 12'(4 * i), {16'h0000, usel, 1'b1, 12'h000});
  endtask

  // Pulse one cycle of slot activity, then look 1 ns after the edge that registers it
  task automatic pulse(input logic [43:0] p);
    @(posedge clk);
    fire <= 1'b1;
    pat <= p;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk("status after reset", 32'h0000_0000, rd);
    apb(1'b1, 12'h030, 32'hFFFF_FFFF);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk("status read only", 32'h0000_0000, rd);
    apb(1'b0, 12'h034, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test regs done");
  endtask

  task automatic t_instr();
    logic [15:0] m [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h000F, 16'h0000};
    logic [2:0] e [6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h0};
    apb(1'b1, 12'h018, {16'h0000, USEL_RETIRE_LO, 1'b1, 12'h000});
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, 12'h000, sel(7'h02, m[k]));
      // Slots: good untagged, good tagged, wrong untagged, wrong tagged
      pulse({32'h0, 4'hA, 4'hC, 4'hF});
      chk("instr count", {29'h0, e[k]}, {29'h0, count_incr[0]});
      chk("idle counter", 32'h0000_0000, {29'h0, count_incr[2]});
    end
    $display("test instr done");
  endtask

  task automatic t_uops();
    logic [15:0] m [3] = '{16'h0001, 16'h0002, 16'h0003};
    logic [2:0] e [3] = '{3'h2, 3'h1, 3'h3};
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, 12'h000, sel(7'h01, m[k]));
      pulse({24'h0, 4'h4, 4'h7, 12'h000});
      chk("uop count", {29'h0, e[k]}, {29'h0, count_incr[0]});
    end
    // Clock enable low must hold the last increment
    @(posedge clk);
    ce <= 1'b0;
    pulse({24'h0, 4'h4, 4'h7, 12'h000});
    chk("frozen count", 32'h0000_0000, {29'h0, count_incr[0]});
    @(posedge clk);
    ce <= 1'b1;
    $display("test uops done");
  endtask

  task automatic t_group();
    cfg_all(USEL_RETIRE_LO);
    apb(1'b1, 12'h000, sel(7'h01, 16'h0001));
    apb(1'b1, 12'h004, sel(7'h01, 16'h0002));
    pulse({24'h0, 4'h4, 4'h7, 12'h000});
    for (int i = 0; i < NUM_CNT; i++)
      chk("group count", (i == 2 || i == 3 || i == 5) ? 32'h1 : 32'h2,
          {29'h0, count_incr[i]});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("sel b readback", sel(7'h01, 16'h0002), rd);
    apb(1'b0, 12'h02C, 32'h0000_0000);
    chk("cfg readback", {16'h0000, USEL_RETIRE_LO, 1'b1, 12'h000}, rd);
    $display("test group done");
  endtask

  task automatic t_branch();
    logic [15:0] m [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0005};
    logic [2:0] e [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2};
    cfg_all(USEL_RETIRE_HI);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, 12'h008, sel(7'h06, m[k]));
      // Slots: not-taken predicted, not-taken mispredicted, taken predicted, taken mispredicted
      pulse({12'h000, 4'hA, 4'hC, 4'hF, 20'h0_0000});
      chk("branch count", {29'h0, e[k]}, {29'h0, count_incr[0]});
    end
    $display("test branch done");
  endtask

  task automatic t_mark();
    logic [15:0] m [3] = '{16'h0002, 16'h0004, 16'h0006};
    logic [3:0] e [3] = '{4'h5, 4'h2, 4'h7};
    cfg_all(USEL_RENAME);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, 12'h010, sel(7'h02, m[k]));
      pulse({4'hA, 4'h5, 4'h7, 4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 12'h00F});
      chk("mark", {28'h0, e[k]}, {28'h0, mark_tag});
      chk("no count", 32'h0000_0000, {14'h0, count_incr});
    end
    $display("test mark done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk("incr after reset", 32'h0000_0000, {14'h0, count_incr});
    t_regs();
    t_instr();
    t_uops();
    t_group();
    t_branch();
    t_mark();
    results();
  end
endmodule // res_event_select_test
